// >>> core/tw_port_pkg.sv
package tw_port_pkg;

  // PCI command codes seen on C/BE# during the address phase
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] CMD_DAC = 4'hD;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;

  // Configuration command register: dword index, enable bits, reset value
  localparam logic [5:0] CFG_COMMAND_DW = 6'h01;
  localparam int CFG_IO_EN_BIT = 0;
  localparam int CFG_MEM_EN_BIT = 1;
  localparam logic [15:0] CFG_COMMAND_RST = 16'h0000;

  // Target state counter values
  localparam logic [3:0] TS_IDLE = 4'h0;
  localparam logic [3:0] TS_DATA0 = 4'h4;
  localparam logic [3:0] TS_DATA3 = 4'h7;

  // Write FIFO shape and thresholds
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int FIFO_W = DATA_W + BE_W;
  localparam int FIFO_DEPTH_DEF = 64;
  localparam int AEMPTY_WIDE_ENTRIES = 4;
  localparam int WORDS_PER_WIDE = 2;
  localparam int ROOM_MARGIN_WORDS = 3;
  localparam logic [3:0] PAD_BE_N = 4'hF;

  // Decode sizes
  localparam int BAR_BITS_DEF = 20;
  localparam int IO_BITS_DEF = 8;

  // Target request gap after a finished transaction
  localparam int TREQ_GAP_CYCLES = 1;

  typedef enum logic [3:0] {P_IDLE, P_DAC, P_WAIT, P_CFG, P_XFER, P_STOP, P_TURN, P_SKIP} pci_state_t;
  typedef enum logic [2:0] {K_NONE, K_CFG, K_MEM, K_IO_POST, K_IO_DLY_NEW, K_IO_DLY_DONE, K_RETRY} kind_t;
  typedef enum logic [1:0] {DLY_NONE, DLY_FWD, DLY_DONE} dly_state_t;

endpackage

// >>> core/tw_fifo.sv
module tw_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Refuse shapes the pointer wrap cannot serve
  if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_shape
    $error("tw_fifo: DEPTH must be a power of two of at least 8");
  end

  // Honest flags from the occupancy count
  assign in_ready = count_reg != FULL_COUNT;
  assign out_valid = count_reg != '0;
  assign out_data = mem[rd_ptr_reg];
  assign count = count_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count; clear empties the buffer at once
  always_ff @(posedge clk or posedge rst or negedge clr_n) begin
    if (rst || !clr_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// >>> core/pci_target_write_fifo_port.sv
// What this block does
// RQ1: Almost-empty goes active at four or fewer 64-bit entries held.
// RQ2: Empty goes active once the application has unloaded every entry.
// RQ3: Empty and almost-empty follow fill and drain freely within a burst.
// RQ4: PCI write ends by master, full disconnect, retry when busy, or reset.
// RQ5: Last-cycle marks final FIFO item, even long after PCI finished.
// RQ6: Target request drops one clock after the last item; reassertion is new.
// RQ7: FIFO clear empties FIFO and zeroes state counter; pulse one clock.
// RQ8: Application must not clear during active request; only bus reset stops PCI.
// RQ9: Configuration writes bypass the FIFO and disconnect with the first word.
// RQ10: Configuration write asserts TRDY# one clock after DEVSEL#.
// RQ11: Posted I/O write completes at once, disconnecting with the first word.
// RQ12: Delayed I/O write is forwarded, retried until done, then completes.
// RQ13: Single memory write completes without STOP#.
// RQ14: Request shows pending work; address enable fetches command and address.
// RQ15: Extension bit 0 carries dual-address, bit 1 burst, off for singles.
// RQ16: Application takes an address word each clock until last-cycle.
// RQ17: Application enters data phase only while data is available.
// RQ18: One write piece per enabled clock on the 32-bit or 18-bit bus.
// RQ19: A single dual-port data word carries last-cycle during its transfer, unless wide_bus_agent adds a pad word after it.
// RQ20: Quad address goes low half first; last-cycle marks top piece, or the lone low half when BAR_BITS is 16 or less without DAC.
// RQ21: Quad data takes two clocks per word; last-cycle on final piece.
// RQ22: Write FIFO holds 64 words of 32 bits.
// RQ23: Alignment padding words carry all byte enables inactive.
// RQ24: Application strobes and indicators are active low on clk rising edge.
module pci_target_write_fifo_port #(
  parameter int FIFO_DEPTH = tw_port_pkg::FIFO_DEPTH_DEF,
  parameter int BAR_BITS = tw_port_pkg::BAR_BITS_DEF,
  parameter int IO_BITS = tw_port_pkg::IO_BITS_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tgt_fifo_clear_n,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic idsel,
  input wire logic [31:0] ad_in,
  input wire logic [3:0] cbe_n_in,
  output logic devsel_n_out,
  output logic devsel_n_oe,
  output logic trdy_n_out,
  output logic trdy_n_oe,
  output logic stop_n_out,
  output logic stop_n_oe,
  input wire logic [31:0] mem_base,
  input wire logic [31:0] io_base,
  input wire logic wide_bus_agent,
  input wire logic delayed_io_en,
  input wire logic quad_mode,
  input wire logic fifo_sel,
  output logic [15:0] cfg_command,
  output logic treq_n,
  output logic [3:0] tcmd,
  input wire logic addr_en_n,
  input wire logic wdata_en_n,
  output logic last_cyc_n,
  output logic [31:0] app_data,
  output logic [3:0] app_datax,
  output logic [17:0] quad_data,
  output logic [3:0] tstate_cntr,
  output logic wr_fifo_empty_n,
  output logic wr_fifo_almost_empty_n
);
  import tw_port_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [CW-1:0] AEMPTY_LEVEL = CW'(AEMPTY_WIDE_ENTRIES * WORDS_PER_WIDE);
  localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
  localparam logic [CW-1:0] MARGIN_C = CW'(ROOM_MARGIN_WORDS);
  localparam logic [CW-1:0] ONE_C = CW'(1);
  localparam logic [3:0] QUAD_SHORT_LAST = (BAR_BITS > 16) ? 4'h1 : 4'h0;

  if (FIFO_DEPTH < 16 || BAR_BITS < 4 || BAR_BITS > 31 || IO_BITS < 2 || IO_BITS > 31) begin : g_bad_param
    $error("pci_target_write_fifo_port: parameter out of range");
  end

  pci_state_t pstate_reg;
  kind_t kind_reg;
  kind_t hit_kind;
  dly_state_t dly_state_reg;
  logic devsel_reg, trdy_reg, stop_reg, drive_reg;
  logic [31:0] addr_lo_reg, addr_hi_reg, dly_addr_reg, lo_now;
  logic [3:0] cmd_reg, ts_reg, addr_last_ts;
  logic dac_reg, burst_reg, first_reg, parity_reg, snooped_reg;
  logic hold_valid_reg;
  logic [FIFO_W-1:0] hold_reg, push_data, head;
  logic [15:0] cfg_command_reg;
  logic hdr_valid_reg, hdr_dly_reg, pci_done_reg, gap_reg, hdr_burst_reg, hdr_dac_reg;
  logic [31:0] hdr_lo_reg, hdr_hi_reg;
  logic [3:0] hdr_cmd_reg;
  logic xfer, room, busy, pad_start, pad_end, snoop_push, push_valid, fifo_in_ready;
  logic treq_act, addr_take, addr_last, data_take, data_last, pop, fifo_out_valid;
  logic [CW-1:0] fifo_count;

  // Write data buffer between PCI and application
  tw_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo ( // [RQ22]
    .clk(clk),
    .rst(rst),
    .clr_n(tgt_fifo_clear_n), // [RQ7]
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(head),
    .count(fifo_count)
  );

  // Address decode and claim class for the current address phase
  always_comb begin
    lo_now = (pstate_reg == P_DAC) ? addr_lo_reg : ad_in;
    busy = hdr_valid_reg || (dly_state_reg != DLY_NONE);
    hit_kind = K_NONE;
    if (cbe_n_in == CMD_CFG_WR && idsel && lo_now[1:0] == 2'b00 && pstate_reg == P_IDLE) begin
      hit_kind = K_CFG; // [RQ9]
    end else if ((cbe_n_in == CMD_MEM_WR || cbe_n_in == CMD_MEM_WR_INV) && cfg_command_reg[CFG_MEM_EN_BIT]
                 && lo_now[31:BAR_BITS] == mem_base[31:BAR_BITS]) begin
      hit_kind = busy ? K_RETRY : K_MEM; // [RQ4]
    end else if (cbe_n_in == CMD_IO_WR && cfg_command_reg[CFG_IO_EN_BIT]
                 && lo_now[31:IO_BITS] == io_base[31:IO_BITS]) begin
      if (dly_state_reg == DLY_DONE && lo_now == dly_addr_reg) begin
        hit_kind = K_IO_DLY_DONE; // [RQ12]
      end else if (busy) begin
        hit_kind = K_RETRY; // [RQ12]
      end else begin
        hit_kind = delayed_io_en ? K_IO_DLY_NEW : K_IO_POST;
      end
    end
  end

  // Data phase qualifiers and FIFO fill source selection
  assign xfer = drive_reg && trdy_reg && !irdy_n;
  assign room = (fifo_count + MARGIN_C) <= DEPTH_C;
  assign pad_start = xfer && first_reg && kind_reg == K_MEM && addr_lo_reg[2] && (!frame_n || wide_bus_agent);
  assign pad_end = pstate_reg == P_TURN && kind_reg == K_MEM && (burst_reg || wide_bus_agent)
                   && parity_reg && !hold_valid_reg;
  assign snoop_push = pstate_reg == P_STOP && kind_reg == K_IO_DLY_NEW && !irdy_n && !snooped_reg;

  always_comb begin
    push_valid = 1'b0;
    push_data = {PAD_BE_N, 32'h0000_0000};
    if (hold_valid_reg) begin
      push_valid = 1'b1;
      push_data = hold_reg;
    end else if (pad_start || pad_end) begin
      push_valid = 1'b1; // [RQ23]
    end else if ((xfer && (kind_reg == K_MEM || kind_reg == K_IO_POST)) || snoop_push) begin
      push_valid = 1'b1;
      push_data = {cbe_n_in, ad_in};
    end
  end

  // PCI target sequencer; only bus reset forces it to idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pstate_reg <= P_IDLE; // [RQ8]
      kind_reg <= K_NONE;
      devsel_reg <= 1'b0;
      trdy_reg <= 1'b0;
      stop_reg <= 1'b0;
      drive_reg <= 1'b0;
      addr_lo_reg <= 32'h0000_0000;
      addr_hi_reg <= 32'h0000_0000;
      cmd_reg <= 4'h0;
      dac_reg <= 1'b0;
      burst_reg <= 1'b0;
      first_reg <= 1'b0;
      parity_reg <= 1'b0;
      snooped_reg <= 1'b0;
      hold_valid_reg <= 1'b0;
      hold_reg <= '0;
    end else begin
      hold_valid_reg <= pad_start;
      if (pad_start) begin
        hold_reg <= {cbe_n_in, ad_in};
      end
      case (pstate_reg)
        P_IDLE: begin
          drive_reg <= 1'b0;
          if (!frame_n) begin
            addr_lo_reg <= ad_in;
            addr_hi_reg <= 32'h0000_0000;
            cmd_reg <= cbe_n_in;
            dac_reg <= 1'b0;
            burst_reg <= 1'b0;
            first_reg <= 1'b1;
            parity_reg <= 1'b0;
            snooped_reg <= 1'b0;
            kind_reg <= hit_kind;
            if (cbe_n_in == CMD_DAC) begin
              pstate_reg <= P_DAC;
            end else begin
              pstate_reg <= (hit_kind == K_NONE) ? P_SKIP : P_WAIT;
            end
          end
        end
        P_DAC: begin
          addr_hi_reg <= ad_in;
          cmd_reg <= cbe_n_in;
          dac_reg <= 1'b1;
          kind_reg <= hit_kind;
          pstate_reg <= (hit_kind == K_NONE) ? P_SKIP : P_WAIT;
        end
        P_WAIT: begin
          drive_reg <= 1'b1;
          devsel_reg <= 1'b1;
          case (kind_reg)
            K_CFG: pstate_reg <= P_CFG; // [RQ10]
            K_MEM: begin
              trdy_reg <= 1'b1; // [RQ13]
              pstate_reg <= P_XFER;
            end
            K_IO_POST, K_IO_DLY_DONE: begin
              trdy_reg <= 1'b1; // [RQ11] [RQ12]
              stop_reg <= 1'b1;
              pstate_reg <= P_XFER;
            end
            default: begin
              stop_reg <= 1'b1; // [RQ4] [RQ12]
              pstate_reg <= P_STOP;
            end
          endcase
        end
        P_CFG: begin
          trdy_reg <= 1'b1; // [RQ10] [RQ9]
          stop_reg <= 1'b1;
          pstate_reg <= P_XFER;
        end
        P_XFER: begin
          if (xfer) begin
            first_reg <= 1'b0;
            if (first_reg) begin
              burst_reg <= !frame_n;
            end
          end
          if (xfer && frame_n) begin
            devsel_reg <= 1'b0; // [RQ4]
            trdy_reg <= 1'b0;
            stop_reg <= 1'b0;
            pstate_reg <= P_TURN;
          end else if (xfer && stop_reg) begin
            trdy_reg <= 1'b0;
            pstate_reg <= P_STOP;
          end else if (xfer || !trdy_reg) begin
            if (!room) begin
              trdy_reg <= 1'b0; // [RQ4]
              stop_reg <= 1'b1;
              pstate_reg <= P_STOP;
            end else begin
              trdy_reg <= !pad_start;
            end
          end
        end
        P_STOP: begin
          trdy_reg <= 1'b0;
          if (snoop_push) begin
            snooped_reg <= 1'b1;
          end
          if (frame_n) begin
            devsel_reg <= 1'b0;
            stop_reg <= 1'b0;
            pstate_reg <= P_TURN;
          end
        end
        P_TURN: begin
          drive_reg <= 1'b0;
          pstate_reg <= P_IDLE;
        end
        P_SKIP: begin
          if (frame_n && irdy_n) begin
            pstate_reg <= P_IDLE;
          end
        end
        default: pstate_reg <= P_IDLE;
      endcase
      if (push_valid) begin
        parity_reg <= !parity_reg;
      end
    end
  end

  // Configuration command register, written with no FIFO activity
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_command_reg <= CFG_COMMAND_RST;
    end else if (xfer && kind_reg == K_CFG && addr_lo_reg[7:2] == CFG_COMMAND_DW) begin
      if (!cbe_n_in[0]) begin
        cfg_command_reg[7:0] <= ad_in[7:0]; // [RQ9]
      end
      if (!cbe_n_in[1]) begin
        cfg_command_reg[15:8] <= ad_in[15:8];
      end
    end
  end

  // Application handshake qualifiers
  assign treq_act = hdr_valid_reg && !gap_reg;
  assign addr_last_ts = quad_mode ? (hdr_dac_reg ? 4'h3 : QUAD_SHORT_LAST) : {3'b000, hdr_dac_reg};
  assign addr_last = ts_reg == addr_last_ts; // [RQ20]
  assign addr_take = treq_act && !addr_en_n && !ts_reg[2]; // [RQ14] [RQ16]
  assign data_take = treq_act && ts_reg[2] && !wdata_en_n && addr_en_n && fifo_out_valid; // [RQ17]
  assign data_last = pci_done_reg && fifo_count == ONE_C && (!quad_mode || ts_reg[0]); // [RQ5] [RQ21]
  assign pop = data_take && (!quad_mode || ts_reg[0]); // [RQ18] [RQ21]

  // Transaction header, delayed I/O tracking and target state counter
  always_ff @(posedge clk or posedge rst or negedge tgt_fifo_clear_n) begin
    if (rst || !tgt_fifo_clear_n) begin
      hdr_valid_reg <= 1'b0;
      hdr_dly_reg <= 1'b0;
      pci_done_reg <= 1'b0;
      gap_reg <= 1'b0;
      ts_reg <= TS_IDLE; // [RQ7]
      dly_state_reg <= DLY_NONE;
      dly_addr_reg <= 32'h0000_0000;
      hdr_lo_reg <= '0;
      hdr_hi_reg <= '0;
      hdr_cmd_reg <= '0;
      hdr_burst_reg <= 1'b0;
      hdr_dac_reg <= 1'b0;
    end else begin
      gap_reg <= 1'b0;
      if (addr_take) begin
        ts_reg <= addr_last ? TS_DATA0 : ts_reg + 4'h1;
      end else if (data_take && data_last) begin
        ts_reg <= TS_IDLE;
        hdr_valid_reg <= 1'b0;
        hdr_dly_reg <= 1'b0;
        pci_done_reg <= 1'b0;
        gap_reg <= TREQ_GAP_CYCLES > 0; // [RQ6]
        if (hdr_dly_reg) begin
          dly_state_reg <= DLY_DONE; // [RQ12]
        end
      end else if (data_take) begin
        if (quad_mode) begin
          ts_reg <= (ts_reg == TS_DATA3) ? TS_DATA0 : ts_reg + 4'h1;
        end else begin
          ts_reg <= {ts_reg[3:1], !ts_reg[0]};
        end
      end
      // Hardware set events placed last so they win over clears
      if (push_valid) begin
        hdr_valid_reg <= 1'b1;
      end
      // Header taken with the first word
      if (push_valid && !hdr_valid_reg) begin
        hdr_lo_reg <= addr_lo_reg; // [RQ14]
        hdr_hi_reg <= addr_hi_reg;
        hdr_cmd_reg <= cmd_reg;
        hdr_burst_reg <= (xfer && first_reg) ? !frame_n : burst_reg; // [RQ15]
        hdr_dac_reg <= dac_reg;
      end
      if (pstate_reg == P_TURN && (kind_reg == K_MEM || kind_reg == K_IO_POST || kind_reg == K_IO_DLY_NEW)) begin
        pci_done_reg <= 1'b1; // [RQ5]
      end
      if (snoop_push) begin
        hdr_dly_reg <= 1'b1;
        dly_state_reg <= DLY_FWD;
        dly_addr_reg <= addr_lo_reg;
      end
      if (xfer && kind_reg == K_IO_DLY_DONE) begin
        dly_state_reg <= DLY_NONE;
      end
    end
  end

  // Application-side buses, active-low indicators
  always_comb begin
    treq_n = !treq_act; // [RQ24]
    tcmd = hdr_cmd_reg;
    tstate_cntr = ts_reg;
    last_cyc_n = !(treq_act && (ts_reg[2] ? data_last : addr_last)); // [RQ19]
    wr_fifo_empty_n = fifo_out_valid; // [RQ2] [RQ3]
    wr_fifo_almost_empty_n = fifo_count > AEMPTY_LEVEL; // [RQ1] [RQ3]
    app_data = 32'h0000_0000;
    app_datax = 4'h0;
    quad_data = 18'h0_0000;
    if (quad_mode) begin
      case (ts_reg)
        4'h0: quad_data = {hdr_burst_reg, hdr_dac_reg, hdr_lo_reg[15:0]}; // [RQ20]
        4'h1: quad_data = {hdr_burst_reg, hdr_dac_reg, hdr_lo_reg[31:16]};
        4'h2: quad_data = {hdr_burst_reg, hdr_dac_reg, hdr_hi_reg[15:0]};
        4'h3: quad_data = {hdr_burst_reg, hdr_dac_reg, hdr_hi_reg[31:16]};
        4'h4, 4'h6: quad_data = {head[33:32], head[15:0]}; // [RQ21]
        4'h5, 4'h7: quad_data = {head[35:34], head[31:16]};
        default: quad_data = 18'h0_0000;
      endcase
    end else if (fifo_sel) begin
      if (ts_reg[2]) begin
        app_data = head[31:0]; // [RQ18]
        app_datax = head[35:32];
      end else begin
        app_data = ts_reg[0] ? hdr_hi_reg : hdr_lo_reg;
        app_datax = {2'b00, hdr_burst_reg, hdr_dac_reg}; // [RQ15]
      end
    end
  end

  // PCI target pins: driven through one turnaround cycle after release
  assign devsel_n_out = !devsel_reg;
  assign trdy_n_out = !trdy_reg;
  assign stop_n_out = !stop_reg;
  assign devsel_n_oe = drive_reg;
  assign trdy_n_oe = drive_reg;
  assign stop_n_oe = drive_reg;
  assign cfg_command = cfg_command_reg;

endmodule

// >>> test/pci_target_write_fifo_port_assertions.sv
module tw_port_checker
  import tw_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tgt_fifo_clear_n,
  input wire logic devsel_n_out,
  input wire logic trdy_n_out,
  input wire logic stop_n_out,
  input wire logic quad_mode,
  input wire logic treq_n,
  input wire logic addr_en_n,
  input wire logic wdata_en_n,
  input wire logic last_cyc_n,
  input wire logic [3:0] tstate_cntr,
  input wire logic wr_fifo_empty_n,
  input wire logic wr_fifo_almost_empty_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pop;
  // A data piece is taken by the application at this edge
  assign pop = tstate_cntr >= TS_DATA0 && !wdata_en_n && addr_en_n && wr_fifo_empty_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_empty_means_aempty: assert property (!wr_fifo_empty_n |-> !wr_fifo_almost_empty_n)
    else $error("almost empty inactive while empty");
  a_treq_gap_after: assert property (pop && !last_cyc_n |=> treq_n)
    else $error("request still active after last piece");
  a_last_to_idle: assert property (pop && !last_cyc_n |=> tstate_cntr == TS_IDLE)
    else $error("state not idle after last piece");
  a_addr_to_data: assert property (!treq_n && !addr_en_n && !last_cyc_n && tstate_cntr < TS_DATA0
    |=> tstate_cntr == TS_DATA0) else $error("no data phase after last address piece");
  a_cfg_trdy_late: assert property ($fell(devsel_n_out) && trdy_n_out && stop_n_out |=> !trdy_n_out)
    else $error("trdy not one cycle after devsel");
  a_clear_empties: assert property (!tgt_fifo_clear_n |-> tstate_cntr == TS_IDLE && !wr_fifo_empty_n)
    else $error("clear left data or state");
  a_quad_two_pieces: assert property (quad_mode && pop && tstate_cntr == TS_DATA0
    |-> last_cyc_n ##1 tstate_cntr == TS_DATA0 + 4'h1) else $error("quad word not split in two");
  a_dual_word_step: assert property (!quad_mode && pop && last_cyc_n && tstate_cntr == TS_DATA0
    |=> tstate_cntr == TS_DATA0 + 4'h1) else $error("dual data step wrong");
  c_empty_toggle: cover property ($rose(wr_fifo_empty_n));
  c_quad_pop: cover property (quad_mode && pop);
  c_stop_no_data: cover property (!stop_n_out && trdy_n_out);
endmodule

bind pci_target_write_fifo_port tw_port_checker tw_port_checker_inst (.clk, .rst, .tgt_fifo_clear_n,
  .devsel_n_out, .trdy_n_out, .stop_n_out, .quad_mode, .treq_n, .addr_en_n, .wdata_en_n, .last_cyc_n,
  .tstate_cntr, .wr_fifo_empty_n, .wr_fifo_almost_empty_n);

// >>> test/tw_app_model.sv
module tw_app_model (
  input wire logic clk,
  input wire logic quad_mode,
  input wire logic stall,
  input wire logic treq_n,
  input wire logic last_cyc_n,
  input wire logic wr_fifo_empty_n,
  input wire logic [3:0] tcmd,
  input wire logic [31:0] app_data,
  input wire logic [3:0] app_datax,
  input wire logic [17:0] quad_data,
  output logic addr_en_n,
  output logic wdata_en_n,
  output int n_d,
  output logic [31:0] got_a,
  output logic [3:0] got_ax,
  output logic [3:0] got_c,
  output logic [31:0] got_d [32],
  output logic [3:0] got_x [32]
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph = 0;
  initial begin
    addr_en_n = 1'b1;
    wdata_en_n = 1'b1;
    n_d = 0;
  end
  // Take address and data pieces on the rising edge
  always @(posedge clk) begin
    if (ph == 0 && !treq_n) ph <= 1;
    if (!addr_en_n && !treq_n) begin
      got_a <= quad_mode ? {quad_data[15:0], got_a[31:16]} : app_data;
      got_ax <= quad_mode ? {2'b00, quad_data[17:16]} : app_datax;
      got_c <= tcmd;
      if (!last_cyc_n) ph <= 2;
    end
    if (!wdata_en_n && wr_fifo_empty_n) begin
      got_d[n_d % 32] <= quad_mode ? {16'h0000, quad_data[15:0]} : app_data;
      got_x[n_d % 32] <= quad_mode ? {2'b00, quad_data[17:16]} : app_datax;
      n_d <= n_d + 1;
      if (!last_cyc_n) ph <= 0;
    end
  end
  // Enables change only at the falling edge
  always @(negedge clk) begin
    addr_en_n <= !(ph == 1 && !stall);
    wdata_en_n <= !(ph == 2 && !stall && wr_fifo_empty_n);
  end
endmodule

// >>> test/test_pci_target_write_fifo_port.sv
module test_pci_target_write_fifo_port
  import tw_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, tgt_fifo_clear_n = 1, frame_n = 1, irdy_n = 1, idsel = 0;
  logic quad_mode = 0, delayed_io_en = 0, stall = 0, stp;
  logic [31:0] ad_in = 0, app_data, got_a;
  logic [31:0] mem_base = 32'h8000_0000, io_base = 32'h0000_1000, dbase = 32'h5A00_0003;
  logic [3:0] cbe_n_in = 4'hF, tcmd, app_datax, tstate_cntr, got_ax, got_c;
  logic devsel_n_out, devsel_n_oe, trdy_n_out, trdy_n_oe, stop_n_out, stop_n_oe, treq_n, last_cyc_n;
  logic addr_en_n, wdata_en_n, wr_fifo_empty_n, wr_fifo_almost_empty_n;
  logic [15:0] cfg_command;
  logic [17:0] quad_data;
  logic [31:0] got_d [32];
  logic [3:0] got_x [32];
  int n_d, n_fail = 0, samples_checked = 0, acc, b, k, i;
  always #5 clk = ~clk;
  pci_target_write_fifo_port #(.FIFO_DEPTH(16), .BAR_BITS(20), .IO_BITS(8)) pci_target_write_fifo_port_inst (
    .clk, .rst, .tgt_fifo_clear_n, .frame_n, .irdy_n, .idsel, .ad_in, .cbe_n_in, .devsel_n_out, .devsel_n_oe,
    .trdy_n_out, .trdy_n_oe, .stop_n_out, .stop_n_oe, .mem_base, .io_base, .wide_bus_agent(1'b0), .delayed_io_en,
    .quad_mode, .fifo_sel(1'b1), .cfg_command, .treq_n, .tcmd, .addr_en_n, .wdata_en_n, .last_cyc_n, .app_data,
    .app_datax, .quad_data, .tstate_cntr, .wr_fifo_empty_n, .wr_fifo_almost_empty_n);
  tw_app_model tw_app_model_inst (.clk, .quad_mode, .stall, .treq_n, .last_cyc_n, .wr_fifo_empty_n, .tcmd,
    .app_data, .app_datax, .quad_data, .addr_en_n, .wdata_en_n, .n_d, .got_a, .got_ax, .got_c, .got_d, .got_x);
  // Value comparison and final verdict
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // PCI master write of n words; acc counts transfers, stp marks a target stop
  task pci_wr(input logic [3:0] cmd, input logic [31:0] addr, input int n);
    int t;
    @(negedge clk);
    frame_n = 0;
    ad_in = addr;
    cbe_n_in = cmd;
    @(negedge clk);
    ad_in = dbase;
    cbe_n_in = 4'h0;
    irdy_n = 0;
    frame_n = (n == 1);
    acc = 0;
    stp = 0;
    for (t = 0; t < 40 && !stp && acc < n; t++) begin
      @(posedge clk);
      if (trdy_n_oe && !trdy_n_out) acc++;
      if (stop_n_oe && devsel_n_oe && !stop_n_out) stp = 1;
      @(negedge clk);
      ad_in = dbase + 32'(acc);
      if (!stp && acc < n) frame_n = (acc >= n - 1);
    end
    if (!stp && acc < n) begin
      n_fail++;
      complete_run();
    end
    if (!frame_n) begin
      frame_n = 1;
      @(negedge clk);
    end
    irdy_n = 1;
    cbe_n_in = 4'hF;
    repeat (4) @(negedge clk);
  endtask
  // Bounded wait until the application has unloaded everything
  task drain;
    int t;
    for (t = 0; t < 300 && !(treq_n === 1'b1 && wr_fifo_empty_n === 1'b0 && addr_en_n === 1'b1); t++) @(negedge clk);
    if (t == 300) begin
      n_fail++;
      complete_run();
    end
  endtask
  task endt(input string s);
    $display("test %s done", s);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("treq_n", 1, 32'(treq_n));
    chk("empty_n", 0, 32'(wr_fifo_empty_n));
    chk("tstate", 0, 32'(tstate_cntr));
    rst = 0;
    endt("reset");
    idsel = 1;
    pci_wr(CMD_CFG_WR, 32'h0000_0004, 1);
    idsel = 0;
    chk("cfg acc", 1, acc);
    chk("cfg stop", 1, 32'(stp));
    chk("cfg treq", 1, 32'(treq_n));
    chk("cfg reg", 32'h0003, 32'(cfg_command));
    endt("config");
    b = n_d;
    pci_wr(CMD_MEM_WR, mem_base + 32'h10, 1);
    chk("mem stop", 0, 32'(stp));
    drain;
    chk("mem pieces", 1, n_d - b);
    chk("mem data", dbase, got_d[b % 32]);
    chk("mem addr", mem_base + 32'h10, got_a);
    chk("mem flags", 0, 32'(got_ax[1:0]));
    chk("mem cmd", 32'(CMD_MEM_WR), 32'(got_c));
    endt("single");
    pci_wr(CMD_IO_WR, io_base + 32'h8, 1);
    chk("pio acc", 1, acc);
    chk("pio stop", 1, 32'(stp));
    drain;
    delayed_io_en = 1;
    for (k = 0; k < 2; k++) begin
      pci_wr(CMD_IO_WR, io_base + 32'hC, 1);
      chk("dio acc", 32'(k), acc);
      chk("dio stop", 1, 32'(stp));
      drain;
      chk("dio addr", io_base + 32'hC, got_a);
    end
    delayed_io_en = 0;
    endt("io");
    for (k = 0; k < 2; k++) begin
      b = n_d;
      pci_wr(CMD_MEM_WR, mem_base + 32'h20 + 32'(4 * k), 4 - k);
      drain;
      chk("burst pieces", 4, n_d - b);
      chk("burst flag", 2, 32'(got_ax[1:0]));
      chk("lead be", k ? 32'(PAD_BE_N) : 0, 32'(got_x[b % 32]));
      for (i = 0; i < 4 - k; i++) chk("burst data", dbase + 32'(i), got_d[(b + k + i) % 32]);
    end
    endt("burst");
    quad_mode = 1;
    b = n_d;
    pci_wr(CMD_MEM_WR, mem_base + 32'h44, 1);
    drain;
    chk("quad pieces", 2, n_d - b);
    chk("quad low", {16'h0000, dbase[15:0]}, got_d[b % 32]);
    chk("quad high", {16'h0000, dbase[31:16]}, got_d[(b + 1) % 32]);
    chk("quad addr", mem_base + 32'h44, got_a);
    chk("quad flags", 0, 32'(got_ax[1:0]));
    quad_mode = 0;
    endt("quad");
    stall = 1;
    b = n_d;
    pci_wr(CMD_MEM_WR, mem_base, 20);
    chk("full stop", 1, 32'(stp));
    chk("full part", 1, 32'(acc > 8 && acc < 20));
    chk("aempty off", 1, 32'(wr_fifo_almost_empty_n));
    k = acc;
    pci_wr(CMD_MEM_WR, mem_base, 1);
    chk("retry acc", 0, acc);
    chk("retry stop", 1, 32'(stp));
    stall = 0;
    drain;
    chk("full pieces", 32'(k + k % 2), n_d - b);
    chk("full flag", 2, 32'(got_ax[1:0]));
    chk("aempty on", 0, 32'(wr_fifo_almost_empty_n));
    endt("full");
    tgt_fifo_clear_n = 0;
    @(negedge clk);
    chk("clr state", 0, 32'(tstate_cntr));
    tgt_fifo_clear_n = 1;
    @(negedge clk);
    endt("clear");
    complete_run();
  end
endmodule
